// File: lrc_defs.svh
// Constants of the log read command handler: register offsets, bit
// positions, command code, log addresses and directory layout.
// Assumes a 32-bit APB with byte addresses, one register per word.
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH

`define LRC_OFF_DATA 8'h00
`define LRC_OFF_FEAT 8'h04
`define LRC_OFF_CNT 8'h08
`define LRC_OFF_LO 8'h0C
`define LRC_OFF_MID 8'h10
`define LRC_OFF_HI 8'h14
`define LRC_OFF_UNIT 8'h18
`define LRC_OFF_OPC 8'h1C
`define LRC_OFF_STAT 8'h20
`define LRC_OFF_ERR 8'h24
`define LRC_OFF_CTL 8'h28

`define LRC_CMD_READ_LOG 8'h2F

`define LRC_ST_BSY 7
`define LRC_ST_DRDY 6
`define LRC_ST_DF 5
`define LRC_ST_DRQ 3
`define LRC_ST_ERR 0

`define LRC_ER_UNC 6
`define LRC_ER_IDNF 4
`define LRC_ER_ABRT 2

`define LRC_CTL_SMART 0
`define LRC_CTL_STREAM 1
`define LRC_CTL_RST 3'h3

`define LRC_LOG_DIR 8'h00
`define LRC_LOG_SMART_ERR 8'h02
`define LRC_LOG_EXT_ERR 8'h03
`define LRC_LOG_SMART_ST 8'h06
`define LRC_LOG_EXT_ST 8'h07
`define LRC_LOG_STREAM_LO 8'h20
`define LRC_LOG_STREAM_HI 8'h22
`define LRC_LOG_DELAYED 8'h23
`define LRC_LOG_HOST_LO 8'h80
`define LRC_LOG_HOST_HI 8'h9F

`define LRC_DIR_SECTORS 16'h0001
`define LRC_HOST_SECTORS 16'h0010
`define LRC_DIR_VERSION 16'h0001
`define LRC_EXT_VERSION 8'h01
`define LRC_EXT_CSUM 8'hFF
`define LRC_BYTE_CSUM 9'h1FF
`define LRC_LAST_WORD 7'h7F

`endif

// File: lrc_pkg.sv
// Types of the log read command handler: sequencer states and the
// packed state record. Constants live in lrc_defs.svh.
package lrc_pkg;

typedef enum logic [1:0] {
    LRC_IDLE = 2'b00,
    LRC_CHECK = 2'b01,
    LRC_BLOCK = 2'b10,
    LRC_XFER = 2'b11
} lrc_fsm_t;

typedef struct packed {
    lrc_fsm_t fsm;
    logic [15:0] feat;
    logic [15:0] cnt;
    logic [15:0] lo;
    logic [15:0] mid;
    logic [15:0] hi;
    logic [7:0] unit;
    logic [7:0] err;
    logic [2:0] ctl;
    logic bsy;
    logic drdy;
    logic df;
    logic drq;
    logic intrq;
    logic slverr;
    logic [31:0] rdata;
    logic [15:0] sec;
    logic [15:0] left;
    logic [6:0] word;
} lrc_state_t;

endpackage : lrc_pkg

// File: lrc_log_read.sv
// Log read command handler: task-file registers over APB, command
// check, PIO data-in of log sectors through a 32-bit data port.
// Assumes one pclk domain; media fault inputs come from logic on pclk.
//
// The address map and the APB slave port were decided locally.
`include "lrc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module lrc_log_read #(
    parameter int ADDR_W = 8,
    parameter logic [15:0] EXT_ERR_SECTORS = 16'h0001,
    parameter logic [15:0] EXT_ST_SECTORS = 16'h0001,
    parameter logic [15:0] STREAM_SECTORS = 16'h0001,
    parameter logic [15:0] DELAYED_SECTORS = 16'h0001
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic media_unc,
    input wire logic media_idnf,
    input wire logic dev_fault,
    output logic intrq
);

    localparam lrc_pkg::lrc_state_t RST = '{
        fsm: lrc_pkg::LRC_IDLE,
        drdy: 1'b1,
        ctl: `LRC_CTL_RST,
        default: '0
    };

    lrc_pkg::lrc_state_t r;
    lrc_pkg::lrc_state_t next_r;

    // Sectors each log holds; zero marks an absent or disabled log
    function automatic logic [15:0] log_size(
        input logic [7:0] a,
        input logic [2:0] c
    );
        logic smart;
        logic strm;
        smart = c[`LRC_CTL_SMART];
        strm = c[`LRC_CTL_STREAM];
        log_size = '0;
        if (a == `LRC_LOG_DIR) begin
            log_size = `LRC_DIR_SECTORS;
        end else if (a == `LRC_LOG_EXT_ERR && smart) begin
            log_size = EXT_ERR_SECTORS;
        end else if (a == `LRC_LOG_EXT_ST && smart) begin
            log_size = EXT_ST_SECTORS;
        end else if (a >= `LRC_LOG_STREAM_LO && a <= `LRC_LOG_STREAM_HI
                     && strm) begin
            log_size = STREAM_SECTORS;
        end else if (a == `LRC_LOG_DELAYED) begin
            log_size = DELAYED_SECTORS;
        end else if (a >= `LRC_LOG_HOST_LO && a <= `LRC_LOG_HOST_HI
                     && smart) begin
            log_size = `LRC_HOST_SECTORS;
        end
    endfunction : log_size

    // One byte of a log sector; content not produced here reads zero
    function automatic logic [7:0] log_byte(
        input logic [7:0] a,
        input logic [15:0] s,
        input logic [8:0] b,
        input logic [2:0] c
    );
        logic [15:0] sz;
        logic [15:0] ver;
        ver = `LRC_DIR_VERSION;
        sz = log_size(b[8:1], c);
        log_byte = '0;
        if (a == `LRC_LOG_DIR) begin
            if (b[8:1] == '0) begin
                log_byte = b[0] ? ver[15:8] : ver[7:0];
            end else begin
                log_byte = b[0] ? sz[15:8] : sz[7:0];
            end
        end else if (a == `LRC_LOG_EXT_ERR && s == '0) begin
            // No entry is ever logged for refused commands
            if (b == '0) begin
                log_byte = `LRC_EXT_VERSION;
            end else if (b == `LRC_BYTE_CSUM) begin
                log_byte = `LRC_EXT_CSUM;
            end
        end
        // Host logs never written, all zero
    endfunction : log_byte

    function automatic logic [31:0] log_word(
        input logic [7:0] a,
        input logic [15:0] s,
        input logic [6:0] w,
        input logic [2:0] c
    );
        log_word = '0;
        for (int k = 0; k < 4; k++) begin
            log_word[k*8 +: 8] = log_byte(a, s, {w, k[1:0]}, c);
        end
    endfunction : log_word

    logic [7:0] status;
    logic [7:0] off;
    logic setup;
    logic access;
    logic [15:0] size;
    logic [15:0] room;
    logic abort;

    assign off = paddr[7:0];
    assign setup = psel && !penable;
    assign access = psel && penable;
    // Log address from the current low byte
    assign size = log_size(r.lo[7:0], r.ctl);
    assign room = size - r.mid;

    always_comb begin
        status = '0;
        status[`LRC_ST_BSY] = r.bsy;
        status[`LRC_ST_DRDY] = r.drdy;
        status[`LRC_ST_DF] = r.df;
        status[`LRC_ST_DRQ] = r.drq;
        status[`LRC_ST_ERR] = |r.err;
    end

    always_comb begin
        abort = 1'b0;
        // Logs owned by the SMART path
        if (r.lo[7:0] == `LRC_LOG_SMART_ERR ||
            r.lo[7:0] == `LRC_LOG_SMART_ST) begin
            abort = 1'b1;
        end
        if (size == '0 || r.feat != '0 || r.hi != '0 ||
            r.lo[15:8] != '0 || r.mid >= size) begin
            abort = 1'b1;
        end
        if (r.cnt == '0) begin
            abort = 1'b1;
        end
        if (r.cnt > size) begin
            abort = 1'b1;
        end
    end

    always_comb begin
        next_r = r;
        if (setup) begin
            next_r.slverr = 1'b0;
            next_r.rdata = '0;
            case (off)
                `LRC_OFF_DATA: begin
                    if (r.drq) begin
                        next_r.rdata = log_word(r.lo[7:0], r.sec,
                                                r.word, r.ctl);
                    end
                end
                `LRC_OFF_FEAT: next_r.rdata = '0;
                `LRC_OFF_CNT: next_r.rdata = {16'h0000, r.cnt};
                `LRC_OFF_LO: next_r.rdata = {16'h0000, r.lo};
                `LRC_OFF_MID: next_r.rdata = {16'h0000, r.mid};
                `LRC_OFF_HI: next_r.rdata = {16'h0000, r.hi};
                // Device select reads back as written
                `LRC_OFF_UNIT: next_r.rdata = {24'h000000, r.unit};
                `LRC_OFF_OPC: next_r.rdata = '0;
                `LRC_OFF_STAT: next_r.rdata = {24'h000000, status};
                `LRC_OFF_ERR: next_r.rdata = {24'h000000, r.err};
                `LRC_OFF_CTL: next_r.rdata = {29'h00000000, r.ctl};
                default: next_r.slverr = 1'b1;
            endcase
        end

        // Reading status acknowledges the interrupt; a set below wins
        if (access && !pwrite && off == `LRC_OFF_STAT) begin
            next_r.intrq = 1'b0;
        end

        // Task-file writes are ignored while a command owns it
        if (access && pwrite && !r.bsy && !r.drq) begin
            case (off)
                // Previous byte takes the old current
                `LRC_OFF_FEAT: next_r.feat = {r.feat[7:0], pwdata[7:0]};
                `LRC_OFF_CNT: next_r.cnt = {r.cnt[7:0], pwdata[7:0]};
                `LRC_OFF_LO: next_r.lo = {r.lo[7:0], pwdata[7:0]};
                `LRC_OFF_MID: next_r.mid = {r.mid[7:0], pwdata[7:0]};
                `LRC_OFF_HI: next_r.hi = {r.hi[7:0], pwdata[7:0]};
                `LRC_OFF_UNIT: next_r.unit = pwdata[7:0];
                `LRC_OFF_CTL: next_r.ctl = pwdata[2:0];
                `LRC_OFF_OPC: begin
                    next_r.bsy = 1'b1;
                    next_r.df = 1'b0;
                    next_r.err = '0;
                    next_r.fsm = lrc_pkg::LRC_CHECK;
                    if (pwdata[7:0] != `LRC_CMD_READ_LOG) begin
                        next_r.bsy = 1'b0;
                        next_r.err[`LRC_ER_ABRT] = 1'b1;
                        next_r.intrq = 1'b1;
                        next_r.fsm = lrc_pkg::LRC_IDLE;
                    end
                end
                default: next_r.slverr = r.slverr;
            endcase
        end

        case (r.fsm)
            lrc_pkg::LRC_IDLE: begin
                next_r.drq = 1'b0;
            end
            // Validate then stream by PIO data-in
            lrc_pkg::LRC_CHECK: begin
                if (abort) begin
                    next_r.err[`LRC_ER_ABRT] = 1'b1;
                    next_r.bsy = 1'b0;
                    next_r.drdy = 1'b1;
                    next_r.intrq = 1'b1;
                    next_r.fsm = lrc_pkg::LRC_IDLE;
                end else if (dev_fault) begin
                    // DF only on a device fault
                    next_r.df = 1'b1;
                    next_r.err[`LRC_ER_ABRT] = 1'b1;
                    next_r.bsy = 1'b0;
                    next_r.intrq = 1'b1;
                    next_r.fsm = lrc_pkg::LRC_IDLE;
                end else begin
                    next_r.sec = r.mid;
                    next_r.left = (r.cnt < room) ? r.cnt : room;
                    next_r.word = '0;
                    next_r.fsm = lrc_pkg::LRC_BLOCK;
                end
            end
            lrc_pkg::LRC_BLOCK: begin
                next_r.bsy = 1'b0;
                next_r.intrq = 1'b1;
                next_r.fsm = lrc_pkg::LRC_IDLE;
                if (media_unc) begin
                    next_r.err[`LRC_ER_UNC] = 1'b1;
                end else if (media_idnf) begin
                    next_r.err[`LRC_ER_IDNF] = 1'b1;
                end else begin
                    next_r.drq = 1'b1;
                    next_r.fsm = lrc_pkg::LRC_XFER;
                end
            end
            lrc_pkg::LRC_XFER: begin
                // Host drains one sector per block
                if (access && !pwrite && off == `LRC_OFF_DATA) begin
                    next_r.word = r.word + 7'h01;
                    if (r.word == `LRC_LAST_WORD) begin
                        next_r.drq = 1'b0;
                        next_r.sec = r.sec + 16'h0001;
                        next_r.left = r.left - 16'h0001;
                        if (r.left == 16'h0001) begin
                            next_r.bsy = 1'b0;
                            next_r.df = 1'b0;
                            next_r.err = '0;
                            next_r.drdy = 1'b1;
                            next_r.fsm = lrc_pkg::LRC_IDLE;
                        end else begin
                            next_r.bsy = 1'b1;
                            next_r.fsm = lrc_pkg::LRC_BLOCK;
                        end
                    end
                end
            end
            default: next_r.fsm = lrc_pkg::LRC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= RST;
        end else begin
            r <= next_r;
        end
    end

    // Read data is latched in the setup cycle, so no wait state
    assign pready = 1'b1;
    assign prdata = r.rdata;
    assign pslverr = r.slverr && access;
    assign intrq = r.intrq;

endmodule : lrc_log_read

`default_nettype wire

// File: lrc_log_read_sva.sv
// Port checker of the log read handler: APB answers and interrupts.
// Assumes one pclk domain; bound to lrc_log_read by the testbench.
`include "lrc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module lrc_log_read_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic media_unc,
    input wire logic media_idnf,
    input wire logic dev_fault,
    input wire logic intrq
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic setup;
    logic opc_wr;
    logic stat_rd;
    assign setup = psel && !penable;
    assign opc_wr = psel && penable && pwrite && paddr == `LRC_OFF_OPC;
    assign stat_rd = setup && !pwrite && paddr == `LRC_OFF_STAT;

    ready_access_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    unmapped_err_a: assert property (setup && paddr > `LRC_OFF_CTL |=> pslverr)
        else $error("no pslverr on unmapped address");
    unmapped_zero_a: assert property (setup && paddr > `LRC_OFF_CTL |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!setup |=> $stable(prdata))
        else $error("prdata changed outside setup edge");
    reset_quiet_a: assert property (disable iff (1'b0) !presetn |-> !intrq && !pslverr && prdata == 32'h0)
        else $error("outputs active in reset");
    abort_irq_a: assert property (opc_wr && pwdata[7:0] != `LRC_CMD_READ_LOG |=> intrq)
        else $error("unknown opcode not aborted at once");
    cmd_irq_a: assert property (opc_wr && pwdata[7:0] == `LRC_CMD_READ_LOG |-> ##[2:4] intrq)
        else $error("no interrupt after log read command");
    err_status_a: assert property (stat_rd ##1 prdata[0] |-> prdata[7:6] == 2'b01 && !prdata[3])
        else $error("error status with busy or data request");

    cover property ($rose(intrq));
    cover property (pslverr);
    cover property (stat_rd ##1 prdata[0]);
endmodule : lrc_log_read_sva

`default_nettype wire

// File: lrc_host_model.sv
// Host adapter model: APB master loading the task file, reading sectors.
// Assumes pclk is the slave's APB clock; every wait is bounded.
`include "lrc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module lrc_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic intrq
);
    int hangs = 0;
    logic last_err;
    logic [31:0] stat;
    logic [31:0] sect [128];

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Request held until pready is sampled high, for at most 16 clocks
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) hangs++;
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wait_irq;
        int n;
        for (n = 0; n < 40 && intrq !== 1'b1; n++) @(posedge pclk);
        if (n == 40) hangs++;
    endtask : wait_irq

    task get_sector;
        wait_irq();
        xfer(1'b0, `LRC_OFF_STAT, 32'h0, stat);
        for (int w = 0; w < 128; w++) xfer(1'b0, `LRC_OFF_DATA, 32'h0, sect[w]);
    endtask : get_sector
endmodule : lrc_host_model

`default_nettype wire

// File: lrc_log_read_tb.sv
// Testbench of the log read handler: host model on APB, media inputs.
// Assumes the register map and codes of lrc_defs.svh.
`include "lrc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module lrc_log_read_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, intrq;
    logic media_unc = 1'b0;
    logic media_idnf = 1'b0;
    logic dev_fault = 1'b0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int mismatches = 0;
    int checked = 0;
    int s;

    always #5 pclk = ~pclk;

    lrc_log_read i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .media_unc(media_unc), .media_idnf(media_idnf),
        .dev_fault(dev_fault), .intrq(intrq));
    lrc_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .intrq(intrq));

    task end_sim;
        mismatches += i_host.hangs;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, {24'h0, d}, q);
    endtask : wr

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        i_host.xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rdc

    // Fields: opcode, feature, count, log, offset; high bytes first
    task cmd(input logic [47:0] c);
        wr(`LRC_OFF_FEAT, 8'h00);
        wr(`LRC_OFF_FEAT, c[39:32]);
        wr(`LRC_OFF_CNT, c[31:24]);
        wr(`LRC_OFF_CNT, c[23:16]);
        wr(`LRC_OFF_LO, 8'h00);
        wr(`LRC_OFF_LO, c[15:8]);
        wr(`LRC_OFF_MID, 8'h00);
        wr(`LRC_OFF_MID, c[7:0]);
        wr(`LRC_OFF_HI, 8'h00);
        wr(`LRC_OFF_HI, 8'h00);
        wr(`LRC_OFF_OPC, c[47:40]);
    endtask : cmd

    task t_reset;
        rdc("state_flags", `LRC_OFF_STAT, 32'h40);
        rdc("fault_flags", `LRC_OFF_ERR, 32'h0);
        rdc("log_control", `LRC_OFF_CTL, 32'h3);
        rdc("unmapped", 8'h30, 32'h0);
        chk("pslverr", 32'h1, {31'h0, i_host.last_err});
        wr(`LRC_OFF_CNT, 8'h12);
        wr(`LRC_OFF_CNT, 8'h34);
        rdc("transfer_count", `LRC_OFF_CNT, 32'h1234);
        wr(`LRC_OFF_UNIT, 8'h10);
    endtask : t_reset

    task t_dir;
        cmd(48'h2F_00_0001_00_00);
        i_host.get_sector();
        chk("state_flags", 32'h48, i_host.stat);
        chk("version", 32'h1, i_host.sect[0]);
        chk("dir word1", 32'h10000, i_host.sect[1]);
        chk("dir word64", 32'h100010, i_host.sect[64]);
        rdc("state_flags", `LRC_OFF_STAT, 32'h40);
        // The clear lands at the access edge; look once it has settled
        @(negedge pclk);
        chk("intrq", 32'h0, {31'h0, intrq});
        rdc("unit_select", `LRC_OFF_UNIT, 32'h10);
    endtask : t_dir

    // Offset 14 of a 16-sector log leaves two sectors for a count of 3
    task t_host;
        logic [31:0] acc;
        acc = 32'h0;
        cmd(48'h2F_00_0003_80_0E);
        for (s = 0; s < 16 - 14; s++) begin
            i_host.get_sector();
            chk("state_flags", 32'h48, i_host.stat);
            for (int w = 0; w < 128; w++) acc |= i_host.sect[w];
        end
        chk("host log", 32'h0, acc);
        rdc("state_flags", `LRC_OFF_STAT, 32'h40);
        cmd(48'h2F_00_0001_03_00);
        i_host.get_sector();
        chk("ext version", 32'h1, i_host.sect[0]);
        chk("ext last", 32'hFF000000, i_host.sect[127]);
    endtask : t_host

    task abort_case(input logic [47:0] c);
        cmd(c);
        i_host.wait_irq();
        rdc("state_flags", `LRC_OFF_STAT, 32'h41);
        rdc("fault_flags", `LRC_OFF_ERR, 32'h4);
    endtask : abort_case

    task t_abort;
        logic [47:0] tbl [9];
        tbl = '{48'h2F_00_0001_02_00, 48'h2F_00_0001_06_00,
            48'h2F_00_0000_00_00, 48'h2F_00_0011_80_00,
            48'h2F_00_0001_80_10, 48'h2F_01_0001_00_00,
            48'h25_00_0001_00_00, 48'h2F_00_0000_02_00,
            48'h2F_00_0001_01_00};
        foreach (tbl[i]) abort_case(tbl[i]);
        wr(`LRC_OFF_CTL, 8'h02);
        abort_case(48'h2F_00_0001_80_00);
        wr(`LRC_OFF_CTL, 8'h03);
    endtask : t_abort

    task t_media;
        for (s = 0; s < 3; s++) begin
            @(posedge pclk);
            media_unc <= (s == 0);
            media_idnf <= (s == 1);
            dev_fault <= (s == 2);
            cmd(48'h2F_00_0001_00_00);
            i_host.wait_irq();
            rdc("state_flags", `LRC_OFF_STAT, s == 2 ? 32'h61 : 32'h41);
            rdc("fault_flags", `LRC_OFF_ERR, 32'h40 >> (2 * s));
        end
    endtask : t_media

    initial begin
        #1 presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_dir();
        t_host();
        t_abort();
        t_media();
        end_sim();
    end

    // A stuck handshake or an overlong run ends at the report
    always @(posedge pclk) begin
        if (i_host.hangs != 0 || $time > 900000) begin
            mismatches++;
            end_sim();
        end
    end
endmodule : lrc_log_read_tb

bind lrc_log_read lrc_log_read_sva #(.ADDR_W(ADDR_W)) i_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .media_unc(media_unc),
    .media_idnf(media_idnf), .dev_fault(dev_fault), .intrq(intrq));

`default_nettype wire
